//--- design/itp_link_gen.sv
// master bit clock and frame sync generator, divided down from the system clock
`timescale 1ns/1ns
`default_nettype none
module itp_link_gen import itp_pkg::*; #(
    parameter int HALF_CYC = LINK_HALF_CYC,
    parameter int BITS = FRAME_BITS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // control
    input wire logic run,
    // generated link timing
    output logic clk_out,
    output logic sync_out
);
    logic [7:0] half_reg;
    logic [15:0] bit_reg;

    ////////////////////////////////////////////////////////////////
    // divider; held at rest while stopped so a restart opens a clean frame
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            half_reg <= 8'h00;
            clk_out <= 1'b0;
        end else if (!run) begin
            half_reg <= 8'h00;
            clk_out <= 1'b0;
        end else if (half_reg == 8'(HALF_CYC - 1)) begin
            half_reg <= 8'h00;
            clk_out <= ~clk_out;
        end else begin
            half_reg <= half_reg + 8'h01;
        end
    end

    // bit counter advances on each rising edge; sync fills the last bit period
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bit_reg <= 16'h0000;
            sync_out <= 1'b0;
        end else if (!run) begin
            bit_reg <= 16'h0000;
            sync_out <= 1'b0;
        end else if (half_reg == 8'(HALF_CYC - 1) && !clk_out) begin
            bit_reg <= (bit_reg == 16'(BITS - 1)) ? 16'h0000 : bit_reg + 16'h0001;
            sync_out <= (bit_reg == 16'(BITS - 2));
        end
    end
endmodule
`default_nettype wire

//--- design/itp_pkg.sv
// shared constants, slot layout and configuration carrier of the tdm data port
package itp_pkg;
    // slot geometry
    localparam int SLOT_BITS = 20;
    localparam int IDX_W = 5;
    localparam logic [IDX_W-1:0] LAST_IDX = 5'h13;
    // default bit positions inside the slot, bit 0 goes first on the wire
    localparam logic [19:0] B1_MASK = 20'h000ff;
    localparam logic [19:0] D_MASK = 20'h00300;
    localparam logic [19:0] M_MASK = 20'h00400;
    localparam logic [19:0] B2_MASK = 20'h7f800;
    localparam logic [19:0] A_MASK = 20'h80000;
    // line state codes seen by the activation logic
    localparam logic [2:0] INFO3 = 3'h3;
    localparam logic [2:0] INFO4 = 3'h4;
    // timing: system clock period and frame period, master bit clock derived
    localparam int CLK_NS = 50;
    localparam int FRAME_US = 125;
    localparam int LINK_HALF_CYC = 5;
    localparam int FRAME_BITS = (FRAME_US * 1000) / (2 * LINK_HALF_CYC * CLK_NS);
    localparam logic [19:0] IDLE_WORD = 20'hfffff;
    // configuration levels from the control side
    typedef struct packed {
        logic te_mode;
        logic free_run_select;
        logic star_mode_enable;
        logic transmit_power_down;
        logic loop_b1;
        logic loop_b2;
        logic loop_d;
        logic line_loop;
        logic analog_loop;
    } itp_cfg_s;
    localparam int CFG_W = $bits(itp_cfg_s);
endpackage

//--- design/itp_tdm_port.sv
// tdm data port: 20-bit slot exchange per frame, master/slave timing, loopbacks
// Functional notes
// - receive bits sampled on 20 falling edges after the sync falling edge only
// - receive input high means one, low means zero
// - transmit driven on 20 rising edges after sync falling edge, else floating
// - with the loop activated all 20 bits are driven each frame outside star mode
// - loop inactive: drive M and A, ones in B1 B2 D, float elsewhere
// - loopback while inactive drives the slots of looped channels
// - terminal: clock and sync withheld and transmit floats until activation
// - terminal free-run: clock and sync run early, B1 B2 D send ones
// - normal transmit is positive logic
// - star mode floats ones and drives zeros low for a wired-and bus
// - activation when sending INFO 4 and receiving INFO 3 (reversed for terminal)
// - loopback output high whenever any loopback is enabled
// - sync is one bit clock wide before the slot, every 125 us
// - network side is slave unless selected master; terminal always master
// - transmit power-down holds line at INFO 0 and port at idle ones
`timescale 1ns/1ns
`default_nettype none
module itp_tdm_port import itp_pkg::*; #(
    parameter logic [19:0] B1_POS = B1_MASK,
    parameter logic [19:0] B2_POS = B2_MASK,
    parameter logic [19:0] D_POS = D_MASK,
    parameter logic [19:0] M_POS = M_MASK,
    parameter logic [19:0] A_POS = A_MASK
) (
    // system clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // link pins: clock and sync levels seen on the wire, receive data
    input wire logic link_bit_clock,
    input wire logic frame_sync_in,
    input wire logic link_receive_data,
    // link pins driven by this end
    output logic link_bit_clock_out,
    output logic link_bit_clock_oe_n,
    output logic frame_sync_out,
    output logic frame_sync_oe_n,
    output logic link_transmit_data_out,
    output logic link_transmit_data_oe_n,
    // configuration and line state
    input wire itp_cfg_s cfg,
    input wire logic [2:0] info_sent,
    input wire logic [2:0] info_received,
    // slot data exchange
    input wire logic [19:0] tx_slot,
    input wire logic tx_load,
    output logic tx_ready,
    output logic [19:0] rx_slot,
    output logic rx_valid,
    // status
    output logic activation_indication,
    output logic loopback_active,
    output logic line_tx_hold_info0
);
    localparam logic [19:0] CH_POS = B1_POS | B2_POS | D_POS;
    localparam logic [19:0] MA_POS = M_POS | A_POS;

    itp_cfg_s cfg_reg;
    logic run, gen_clk, gen_sync;
    logic tx_req_reg, ack_seen_reg, rx_seen_reg;
    logic [19:0] tx_hold_reg;
    logic [2:0] ack_sy, rxt_sy;
    // link domain
    logic [1:0] lrst_sy;
    logic lrst_n;
    logic [CFG_W:0] lk_s1, lk_s2, lk_s3, lk_v;
    itp_cfg_s cfg_lk;
    logic act_lk;
    logic ln_act, ln_start, rx_tgl;
    logic [IDX_W-1:0] ln_cnt, tp_idx, nidx;
    logic [19:0] rx_sh, rx_word;
    logic tp_act, nact, ack_tgl;
    logic [2:0] req_sy;
    logic [19:0] tx_cur, sl_drv, sl_val;
    logic te_block;
    logic [CFG_W:0] lk_src;
    logic tx_take;
    logic [19:0] tx_word;

    ////////////////////////////////////////////////////////////////
    // system side: configuration, activation and status flags
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfg_reg <= '0;
            activation_indication <= 1'b0;
            loopback_active <= 1'b0;
            line_tx_hold_info0 <= 1'b0;
        end else begin
            cfg_reg <= cfg;
            activation_indication <= cfg.te_mode ? (info_sent == INFO3 && info_received == INFO4)
                                                 : (info_sent == INFO4 && info_received == INFO3);
            loopback_active <= cfg.loop_b1 | cfg.loop_b2 | cfg.loop_d
                             | cfg.line_loop | cfg.analog_loop;
            line_tx_hold_info0 <= cfg.transmit_power_down;
        end
    end

    // master timing: terminal always master, network only when selected
    assign run = (cfg_reg.te_mode | cfg_reg.free_run_select)
               & (!cfg_reg.te_mode | activation_indication | cfg_reg.free_run_select);

    itp_link_gen u_gen (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .run(run),
        .clk_out(gen_clk),
        .sync_out(gen_sync)
    );

    // pin drivers for clock and sync; floating while slave or withheld
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            link_bit_clock_out <= 1'b0;
            frame_sync_out <= 1'b0;
            link_bit_clock_oe_n <= 1'b1;
            frame_sync_oe_n <= 1'b1;
        end else begin
            link_bit_clock_out <= gen_clk;
            frame_sync_out <= gen_sync;
            link_bit_clock_oe_n <= !run;
            frame_sync_oe_n <= !run;
        end
    end

    ////////////////////////////////////////////////////////////////
    // transmit word handshake: hold register stays still until the link acks
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tx_req_reg <= 1'b0;
            tx_hold_reg <= IDLE_WORD;
            ack_sy <= 3'h0;
            ack_seen_reg <= 1'b0;
        end else begin
            ack_sy <= {ack_sy[1:0], ack_tgl};
            if (ack_sy[1] == ack_sy[2]) begin
                ack_seen_reg <= ack_sy[2];
            end
            if (tx_load && tx_ready) begin
                tx_hold_reg <= tx_slot;
                tx_req_reg <= ~tx_req_reg;
            end
        end
    end
    assign tx_ready = (tx_req_reg == ack_seen_reg);

    // receive word: link toggles once per slot, word then stable for a frame
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rxt_sy <= 3'h0;
            rx_seen_reg <= 1'b0;
            rx_slot <= 20'h00000;
            rx_valid <= 1'b0;
        end else begin
            rxt_sy <= {rxt_sy[1:0], rx_tgl};
            rx_valid <= 1'b0;
            if (rxt_sy[1] == rxt_sy[2] && rxt_sy[2] != rx_seen_reg) begin
                rx_seen_reg <= rxt_sy[2];
                rx_slot <= rx_word;
                rx_valid <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // link domain reset: asserted at once, released on the link clock
    always_ff @(posedge link_bit_clock or negedge reset_n) begin
        if (!reset_n) begin
            lrst_sy <= 2'h0;
        end else begin
            lrst_sy <= {lrst_sy[0], 1'b1};
        end
    end
    assign lrst_n = lrst_sy[1];

    // configuration and activation levels into the link domain
    assign lk_src = {activation_indication, cfg_reg};
    for (genvar gi = 0; gi <= CFG_W; gi++) begin : g_cfg_sync
        always_ff @(posedge link_bit_clock or negedge reset_n) begin
            if (!reset_n) begin
                lk_s1[gi] <= 1'b0;
                lk_s2[gi] <= 1'b0;
                lk_s3[gi] <= 1'b0;
                lk_v[gi] <= 1'b0;
            end else begin
                lk_s1[gi] <= lk_src[gi];
                lk_s2[gi] <= lk_s1[gi];
                lk_s3[gi] <= lk_s2[gi];
                if (lk_s2[gi] == lk_s3[gi]) begin
                    lk_v[gi] <= lk_s3[gi];
                end
            end
        end
    end
    assign cfg_lk = itp_cfg_s'(lk_v[CFG_W-1:0]);
    assign act_lk = lk_v[CFG_W];

    ////////////////////////////////////////////////////////////////
    // receive shifter on falling edges; sync seen high opens the slot
    always_ff @(negedge link_bit_clock or negedge reset_n) begin
        if (!reset_n) begin
            ln_act <= 1'b0;
            ln_start <= 1'b0;
            ln_cnt <= '0;
            rx_sh <= 20'h00000;
            rx_word <= 20'h00000;
            rx_tgl <= 1'b0;
        end else if (!lrst_n) begin
            ln_act <= 1'b0;
            ln_start <= 1'b0;
        end else begin
            ln_start <= frame_sync_in;
            if (frame_sync_in) begin
                ln_act <= 1'b1;
                ln_cnt <= '0;
            end else if (ln_act) begin
                rx_sh <= {link_receive_data, rx_sh[19:1]};
                ln_cnt <= ln_cnt + 5'h01;
                if (ln_cnt == LAST_IDX) begin
                    ln_act <= 1'b0;
                    rx_word <= {link_receive_data, rx_sh[19:1]};
                    rx_tgl <= ~rx_tgl;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // per-bit drive and value of the transmit slot
    assign te_block = cfg_lk.te_mode & !act_lk & !cfg_lk.free_run_select;
    for (genvar gb = 0; gb < SLOT_BITS; gb++) begin : g_slot
        logic lbk, src;
        assign lbk = (cfg_lk.loop_b1 & B1_POS[gb]) | (cfg_lk.loop_b2 & B2_POS[gb])
                   | (cfg_lk.loop_d & D_POS[gb]);
        assign src = lbk ? rx_word[gb] : tx_word[gb];
        assign sl_drv[gb] = !te_block & (act_lk | CH_POS[gb] | MA_POS[gb] | lbk);
        assign sl_val[gb] = cfg_lk.transmit_power_down ? 1'b1
                          : (!act_lk & CH_POS[gb] & !lbk) ? 1'b1 : src;
    end

    // next bit index: slot starts on the rising edge after the sync falling edge
    assign nidx = ln_start ? '0 : tp_idx + 5'h01;
    assign nact = ln_start | (tp_act & (tp_idx != LAST_IDX));

    // transmit on rising edges; star mode floats ones for the wired-and bus
    always_ff @(posedge link_bit_clock or negedge reset_n) begin
        if (!reset_n) begin
            tp_act <= 1'b0;
            tp_idx <= '0;
            link_transmit_data_out <= 1'b1;
            link_transmit_data_oe_n <= 1'b1;
        end else if (!lrst_n) begin
            tp_act <= 1'b0;
            link_transmit_data_oe_n <= 1'b1;
        end else begin
            tp_act <= nact;
            tp_idx <= nidx;
            link_transmit_data_out <= !cfg_lk.star_mode_enable & sl_val[nidx];
            link_transmit_data_oe_n <= !(nact & sl_drv[nidx]
                                       & !(cfg_lk.star_mode_enable & sl_val[nidx]));
        end
    end

    // take a new word only at slot start; bit 0 of that slot already reads the new word,
    // so a frame never mixes two words (hold register is still while the request pends)
    assign tx_take = ln_start & (req_sy[1] == req_sy[2]) & (req_sy[2] != ack_tgl);
    assign tx_word = tx_take ? tx_hold_reg : tx_cur;
    always_ff @(posedge link_bit_clock or negedge reset_n) begin
        if (!reset_n) begin
            req_sy <= 3'h0;
            ack_tgl <= 1'b0;
            tx_cur <= IDLE_WORD;
        end else begin
            req_sy <= {req_sy[1:0], tx_req_reg};
            if (tx_take) begin
                tx_cur <= tx_hold_reg;
                ack_tgl <= req_sy[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks on the link side
    sequence s_slot_run;
        tp_act [*8];
    endsequence

    rx_slot_count_a: assert property (@(negedge link_bit_clock) disable iff (!lrst_n)
        (frame_sync_in && !ln_act) |-> ##21 (rx_tgl != $past(rx_tgl, 21)))
        else $error("receive slot did not close after 20 falling edges");
    tx_float_idle_a: assert property (@(posedge link_bit_clock) disable iff (!lrst_n)
        !tp_act |-> link_transmit_data_oe_n)
        else $error("transmit driven outside the slot");
    tx_slot_open_a: assert property (@(posedge link_bit_clock) disable iff (!lrst_n)
        (ln_start && !tp_act) |=> s_slot_run)
        else $error("transmit slot ended early");
    active_all_a: assert property (@(posedge link_bit_clock) disable iff (!lrst_n)
        (tp_act && act_lk && !cfg_lk.star_mode_enable && $stable(lk_v)) |-> !link_transmit_data_oe_n)
        else $error("active loop left a bit undriven");
    te_withhold_a: assert property (@(posedge link_bit_clock) disable iff (!lrst_n)
        ($past(te_block) && te_block) |-> link_transmit_data_oe_n)
        else $error("terminal drove data before activation");
    idle_ones_a: assert property (@(posedge link_bit_clock) disable iff (!lrst_n)
        ($past(cfg_lk.transmit_power_down) && !link_transmit_data_oe_n) |-> link_transmit_data_out)
        else $error("power-down did not send idle ones");
    star_low_a: assert property (@(posedge link_bit_clock) disable iff (!lrst_n)
        ($past(cfg_lk.star_mode_enable) && !link_transmit_data_oe_n) |-> !link_transmit_data_out)
        else $error("star mode drove a high level");

    // checks on the system side
    loop_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ##1 loopback_active == $past(cfg.loop_b1 | cfg.loop_b2 | cfg.loop_d | cfg.line_loop | cfg.analog_loop))
        else $error("loopback output disagrees with enables");
    act_ind_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!cfg.te_mode && info_sent == INFO4 && info_received == INFO3) |=> activation_indication)
        else $error("network activation not indicated");
    slave_float_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!cfg_reg.te_mode && !cfg_reg.free_run_select) |=> (frame_sync_oe_n && link_bit_clock_oe_n))
        else $error("network slave drove clock or sync");
endmodule
`default_nettype wire

//--- verification/itp_link_partner.sv
// far-side model of the tdm data link: slave-mode bit clock, frame sync, receive data, transmit capture
`timescale 1ns/1ns
`default_nettype none
module itp_link_partner #(
    parameter int FRAME_LEN = 32
) (
    // link pins driven by the far side
    output logic link_clk,
    output logic sync,
    output logic rxd,
    // transmit pin of the port as split into value and enable
    input wire logic txd,
    input wire logic txd_oe_n,
    // word sent into the slot and what came back in the last full frame
    input wire logic [19:0] send_word,
    output logic [19:0] got_data,
    output logic [19:0] got_drive,
    output logic outside_float,
    output var int frames
);
    logic [19:0] acc_data;
    logic [19:0] acc_drive;
    logic acc_float;
    ////////////////////////////////////////////////////////////
    // frames are kept short so a run sees many of them; the port as slave accepts any spacing
    initial begin
        link_clk = 1'b0;
        sync = 1'b0;
        rxd = 1'b0;
        frames = 0;
        got_data = 20'h00000;
        got_drive = 20'h00000;
        outside_float = 1'b0;
        #37;
        forever begin
            acc_float = 1'b1;
            for (int k = 0; k < FRAME_LEN; k++) begin
                link_clk = 1'b1; // bench rate is faster than a real backplane clock
                sync = (k == 0); // one bit period high just before the slot
                rxd = (k >= 1 && k <= 20) ? send_word[k-1] : ~rxd; // noise toggles outside the slot
                #80;
                link_clk = 1'b0;
                if (k >= 1 && k <= 20) begin
                    acc_data[k-1] = txd;
                    acc_drive[k-1] = ~txd_oe_n;
                end
                if (k == 0 || k == 21) begin
                    acc_float = acc_float & txd_oe_n;
                end
                #80;
            end
            // publish a whole frame at once so the bench never sees a half-filled capture
            got_data = acc_data;
            got_drive = acc_drive;
            outside_float = acc_float;
            frames++;
        end
    end
endmodule
`default_nettype wire

//--- verification/itp_tdm_port_bench.sv
// self-checking bench of the tdm data port, link slave and master modes
`timescale 1ns/1ns
`default_nettype none
module itp_tdm_port_bench import itp_pkg::*;;
    localparam int WATCHDOG_NS = 3000000;
    logic clk_sys, reset_n, tx_load, tx_ready, rx_valid, p_clk, p_sync, rxd, clk_w, sync_w;
    logic clk_out, clk_oe_n, sync_out, sync_oe_n, txd, txd_oe_n, act, lb_act, hold0, outside_float;
    logic [2:0] info_sent, info_received;
    logic [19:0] tx_slot, rx_slot, got_data, got_drive;
    itp_cfg_s cfg, c;
    int frames, err_count, checks, n, h;
    // wire levels: the port's own drive wins whenever it enables it
    assign clk_w = clk_oe_n ? p_clk : clk_out;
    assign sync_w = sync_oe_n ? p_sync : sync_out;
    itp_tdm_port dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .link_bit_clock(clk_w), .frame_sync_in(sync_w),
        .link_receive_data(rxd), .link_bit_clock_out(clk_out), .link_bit_clock_oe_n(clk_oe_n),
        .frame_sync_out(sync_out), .frame_sync_oe_n(sync_oe_n), .link_transmit_data_out(txd),
        .link_transmit_data_oe_n(txd_oe_n), .cfg(cfg), .info_sent(info_sent), .info_received(info_received),
        .tx_slot(tx_slot), .tx_load(tx_load), .tx_ready(tx_ready), .rx_slot(rx_slot), .rx_valid(rx_valid),
        .activation_indication(act), .loopback_active(lb_act), .line_tx_hold_info0(hold0));
    itp_link_partner partner_u (.link_clk(p_clk), .sync(p_sync), .rxd(rxd), .txd(txd), .txd_oe_n(txd_oe_n),
        .send_word(20'h5a3c9), .got_data(got_data), .got_drive(got_drive), .outside_float(outside_float),
        .frames(frames));
    ////////////////////////////////////////////////////////////
    // clock and watchdog; a hang counts as a mismatch
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        #WATCHDOG_NS;
        err_count++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////
    // shared tasks
    task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_clk(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    task automatic settle(input itp_cfg_s v, input logic [2:0] s, input logic [2:0] r);
        @(negedge clk_sys);
        cfg = v;
        info_sent = s;
        info_received = r;
        // the link side sees a change only after up to four link clocks
        wait_clk(20);
    endtask
    // frame count moves on the link clock, so the wait is bounded in system clocks
    task automatic wait_frames(input int k);
        int f;
        f = frames + k;
        for (int i = 0; i < 4000 && frames < f; i++) @(negedge clk_sys);
    endtask
    // load a word; with refuse set a second load is tried while the hold register is still busy
    task automatic push(input logic [19:0] w, input logic refuse);
        for (int i = 0; i < 2000 && tx_ready !== 1'b1; i++) @(negedge clk_sys);
        tx_slot = w;
        tx_load = 1'b1;
        @(negedge clk_sys);
        chk("tx ready busy", 20'h0, 20'(tx_ready));
        tx_slot = ~w;
        tx_load = refuse;
        @(negedge clk_sys);
        tx_load = 1'b0;
        for (int i = 0; i < 2000 && tx_ready !== 1'b1; i++) @(negedge clk_sys);
        wait_frames(2);
    endtask
    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        err_count = 0;
        checks = 0;
        reset_n = 1'b0;
        cfg = '0;
        info_sent = 3'h0;
        info_received = 3'h0;
        tx_slot = 20'h00000;
        tx_load = 1'b0;
        wait_clk(8);
        chk("clock oe_n after reset", 20'h1, clk_oe_n);
        chk("tx oe_n in reset", 20'h1, txd_oe_n);
        reset_n = 1'b1;
        end_test("reset");
        // every loopback alone raises the flag, terminal and network configurations alternating
        for (int i = 0; i < 5; i++) begin
            c = '0;
            c[i] = 1'b1;
            c.te_mode = i[0];
            settle(c, 3'h0, 3'h0);
            chk("loopback flag", 20'h1, lb_act);
        end
        settle('0, 3'h0, 3'h0);
        chk("loopback flag off", 20'h0, lb_act);
        end_test("loopback flag");
        settle('0, INFO4, INFO3);
        chk("activation network", 20'h1, act);
        settle('0, INFO3, INFO4);
        chk("activation network swapped", 20'h0, act);
        c = '0;
        c.te_mode = 1'b1;
        settle(c, INFO3, INFO4);
        chk("activation terminal", 20'h1, act);
        end_test("activation");
        // active loop: whole slot both ways, two words in turn, a refused load
        settle('0, INFO4, INFO3);
        push(20'h3c5a6, 1'b0);
        for (int i = 0; i < 2000 && rx_valid !== 1'b1; i++) @(negedge clk_sys);
        chk("rx slot", 20'h5a3c9, rx_slot);
        chk("drive active", 20'hfffff, got_drive);
        chk("data active", 20'h3c5a6, got_data);
        chk("float outside slot", 20'h1, outside_float);
        push(20'h8f00f, 1'b1);
        chk("busy load ignored", 20'h8f00f, got_data);
        end_test("active transfer");
        // inactive loop: idle ones in channels, word bits only in maintenance and activation slots
        settle('0, 3'h0, 3'h0);
        wait_frames(2);
        chk("drive inactive", B1_MASK | B2_MASK | D_MASK | M_MASK | A_MASK, got_drive);
        chk("data inactive", B1_MASK | B2_MASK | D_MASK | (20'h8f00f & (M_MASK | A_MASK)), got_data);
        c = '0;
        c.loop_b1 = 1'b1;
        settle(c, 3'h0, 3'h0);
        wait_frames(2);
        chk("loop drive", 20'hfffff, got_drive);
        chk("loop data", B2_MASK | D_MASK | (20'h5a3c9 & B1_MASK) | (20'h8f00f & (M_MASK | A_MASK)), got_data);
        end_test("inactive");
        c = '0;
        c.star_mode_enable = 1'b1;
        settle(c, INFO4, INFO3);
        push(20'h12345, 1'b0);
        chk("star drive", ~20'h12345, got_drive);
        chk("star driven level", 20'h00000, got_data & got_drive);
        c = '0;
        c.transmit_power_down = 1'b1;
        settle(c, INFO4, INFO3);
        wait_frames(2);
        chk("power down data", 20'hfffff, got_data);
        chk("power down line", 20'h1, hold0);
        end_test("star and power down");
        // terminal without activation keeps clock, sync and data off the wire
        c = '0;
        c.te_mode = 1'b1;
        settle(c, 3'h0, 3'h0);
        h = 0;
        repeat (3000) begin
            @(negedge clk_sys);
            h = h | (clk_oe_n !== 1'b1) | (sync_oe_n !== 1'b1) | (txd_oe_n !== 1'b1);
        end
        chk("terminal withheld", 20'h0, 20'(h));
        c.free_run_select = 1'b1;
        settle(c, 3'h0, 3'h0);
        chk("free run clock drive", 20'h0, clk_oe_n);
        n = 0;
        while (sync_out !== 1'b0 && n < 3000) begin @(negedge clk_sys); n++; end
        while (sync_out !== 1'b1 && n < 6000) begin @(negedge clk_sys); n++; end
        h = 0;
        while (sync_out === 1'b1 && h < 3000) begin @(negedge clk_sys); h++; end
        n = h;
        while (sync_out !== 1'b1 && n < 6000) begin @(negedge clk_sys); n++; end
        chk("sync width", 20'(2 * LINK_HALF_CYC), 20'(h));
        chk("sync period", 20'(FRAME_BITS * 2 * LINK_HALF_CYC), 20'(n));
        h = 0;
        while (clk_out !== 1'b1 && h < 100) begin @(negedge clk_sys); h++; end
        h = 0;
        while (clk_out === 1'b1 && h < 100) begin @(negedge clk_sys); h++; end
        chk("clock high width", 20'(LINK_HALF_CYC), 20'(h));
        c.te_mode = 1'b0;
        settle(c, 3'h0, 3'h0);
        chk("network master select", 20'h0, clk_oe_n);
        settle('0, 3'h0, 3'h0);
        chk("network slave again", 20'h1, clk_oe_n);
        end_test("master timing");
        finish_test();
    end
endmodule
`default_nettype wire
